// File: verilog/ssdb_core.sv
// serial peripheral status flags, data buffer and a compact shift engine
// assumes a classic Wishbone master on clk_i; link pins are asynchronous to clk_i
`timescale 1ns/1ps
`include "ssdb_consts.svh"

// What this block does
// RULE_01 - status register read-only, writes ignored
// RULE_02 - receive-complete bit 7 set on data move
// RULE_03 - transmit-empty bit 5 high when buffer free
// RULE_04 - mode-fault bit 4 on select low
// RULE_05 - mode fault cleared: status read, control write
// RULE_06 - low byte read after status read clears
// RULE_07 - wide mode low-only read loses high byte
// RULE_08 - low byte write after status read clears
// RULE_09 - data writes ignored while transmit-empty clear
// RULE_10 - wide mode low-only write: high byte undefined
// RULE_11 - data readable anytime, valid when flag set
// RULE_12 - master sends queued word right after previous
// RULE_13 - received word copied when flag clear
// RULE_14 - second word held while flag unserviced
// RULE_15 - timely service moves held word, flag stays
// RULE_16 - late service drops held word
// RULE_17 - mode fault requests interrupt when enabled
// RULE_18 - flagless status bits read zero
module ssdb_core
   import ssdb_pkg::*;
#(
   parameter int HALF_CYC = `SSDB_SCK_HALF_NS / `SSDB_CLK_NS
) (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [5:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // interrupt
   output logic             irq_o,
   // link pins
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   input  wire logic        ss_n_i
);

   function automatic logic top_bit(input logic [15:0] w, input logic wide);
      top_bit = wide ? w[15] : w[7];
   endfunction

   // pin synchronisers
   logic        sck_m, sck_s, sck_d;
   logic        mosi_m, mosi_s;
   logic        miso_m, miso_s;
   logic        ss_n_m, ss_n_s, ss_n_d;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_m  <= 1'b0;
         sck_s  <= 1'b0;
         sck_d  <= 1'b0;
         mosi_m <= 1'b0;
         mosi_s <= 1'b0;
         miso_m <= 1'b0;
         miso_s <= 1'b0;
         ss_n_m <= 1'b1;
         ss_n_s <= 1'b1;
         ss_n_d <= 1'b1;
      end else if (ce_i) begin
         sck_m  <= sck_i;
         sck_s  <= sck_m;
         sck_d  <= sck_s;
         mosi_m <= mosi_i;
         mosi_s <= mosi_m;
         miso_m <= miso_i;
         miso_s <= miso_m;
         ss_n_m <= ss_n_i;
         ss_n_s <= ss_n_m;
         ss_n_d <= ss_n_s;
      end
   end

   // state
   ssdb_state_e state;
   logic        rcf, rcf_arm, tef, tef_arm, mff, mff_arm;
   logic        ie, mst, transfer_width_select, mfde;
   logic [7:0]  ctrl1_rest, ctrl2_rest;
   logic [15:0] data_rx, held, sh;
   logic        held_v, hi_rd, samp;
   logic [7:0]  tx_hi, tx_lo;
   logic [4:0]  bit_cnt;
   logic [15:0] div_cnt;
   logic [2:0]  irq_stat, irq_mask;

   // bus decode
   logic        req, rd, wr;
   logic [3:0]  idx;
   logic        st_rd, st_wr, dh_rd, dl_rd, dh_wr, dl_wr, c1_wr, c2_wr, is_wr, im_wr;
   assign req   = cyc_i & stb_i & ~ack_o & ce_i;
   assign idx   = adr_i[5:2];
   assign rd    = req & ~we_i & sel_i[0];
   assign wr    = req & we_i & sel_i[0];
   assign st_rd = rd & (idx == `SSDB_IDX_STATUS);
   assign st_wr = wr & (idx == `SSDB_IDX_STATUS);
   assign dh_rd = rd & (idx == `SSDB_IDX_DATAH);
   assign dl_rd = rd & (idx == `SSDB_IDX_DATAL);
   assign dh_wr = wr & (idx == `SSDB_IDX_DATAH);
   assign dl_wr = wr & (idx == `SSDB_IDX_DATAL);
   assign c1_wr = wr & (idx == `SSDB_IDX_CTRL1);
   assign c2_wr = wr & (idx == `SSDB_IDX_CTRL2);
   assign is_wr = wr & (idx == `SSDB_IDX_IRQ_STAT);
   assign im_wr = wr & (idx == `SSDB_IDX_IRQ_MASK);

   // engine events
   logic        tick, mf_evt, m_start, s_start, xfer_start, rise_e, fall_e, abort_e, done_e, rcf_clr;
   logic [4:0]  nbits;
   logic [15:0] shifted, rx_word;
   assign tick       = (div_cnt == 16'(HALF_CYC - 1));
   assign nbits      = transfer_width_select ? `SSDB_BITS_WIDE : `SSDB_BITS_NARROW;
   assign mf_evt     = ce_i & mst & mfde & ~ss_n_s;
   assign m_start    = ce_i & (state == ST_IDLE) & mst & ~tef & ~mf_evt;
   assign s_start    = ce_i & (state == ST_IDLE) & ~mst & ~ss_n_s & ss_n_d;
   assign xfer_start = m_start | s_start;
   assign rise_e     = ce_i & (state == ST_SHIFT) & (mst ? (tick & ~sck_o) : (sck_s & ~sck_d & ~ss_n_s));
   assign fall_e     = ce_i & (state == ST_SHIFT) & (mst ? (tick & sck_o) : (~sck_s & sck_d & ~ss_n_s));
   assign abort_e    = ce_i & (state == ST_SHIFT) & (mst ? mf_evt : ss_n_s);
   assign done_e     = fall_e & ~abort_e & (bit_cnt == nbits);
   assign shifted    = {sh[14:0], samp};
   assign rx_word    = transfer_width_select ? shifted : {`SSDB_BYTE_RST, shifted[7:0]};
   // RULE_06 armed clear
   assign rcf_clr    = dl_rd & rcf_arm & rcf;

   // shift engine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ST_IDLE;
         sh      <= 16'h0000;
         samp    <= 1'b0;
         bit_cnt <= 5'h00;
         div_cnt <= 16'h0000;
         sck_o   <= 1'b0;
      end else if (ce_i) begin
         case (state)
            ST_IDLE: begin
               sck_o   <= 1'b0;
               div_cnt <= 16'h0000;
               bit_cnt <= 5'h00;
               // RULE_12 immediate master start
               if (xfer_start) begin
                  sh    <= transfer_width_select ? {tx_hi, tx_lo} : {`SSDB_BYTE_RST, tx_lo};
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
               if (mst && tick) begin
                  sck_o <= ~sck_o;
               end
               if (rise_e) begin
                  samp    <= mst ? miso_s : mosi_s;
                  bit_cnt <= bit_cnt + 5'h01;
               end
               if (fall_e) begin
                  sh <= shifted;
               end
               if (abort_e || done_e) begin
                  sck_o <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // control registers and mode fault
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ie      <= 1'b0;
         mst     <= 1'b0;
         transfer_width_select    <= 1'b0;
         mfde    <= 1'b0;
         mff     <= 1'b0;
         mff_arm <= 1'b0;
         ctrl1_rest <= `SSDB_BYTE_RST;
         ctrl2_rest <= `SSDB_BYTE_RST;
      end else if (ce_i) begin
         if (c1_wr) begin
            ie         <= dat_i[`SSDB_C1_IE];
            mst        <= dat_i[`SSDB_C1_MSTR];
            ctrl1_rest <= dat_i[7:0];
         end
         if (c2_wr) begin
            transfer_width_select       <= dat_i[`SSDB_C2_TRANSFER_WIDTH_SELECT];
            mfde       <= dat_i[`SSDB_C2_MFDE];
            ctrl2_rest <= dat_i[7:0];
         end
         if (st_rd) begin
            mff_arm <= mff;
         end
         // RULE_05 read then control write
         if (c1_wr && mff_arm) begin
            mff     <= 1'b0;
            mff_arm <= 1'b0;
         end
         // RULE_04 select low as master
         if (mf_evt) begin
            mff <= 1'b1;
            mst <= 1'b0;
         end
      end
   end

   // receive side
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rcf     <= 1'b0;
         rcf_arm <= 1'b0;
         data_rx <= 16'h0000;
         held    <= 16'h0000;
         held_v  <= 1'b0;
         hi_rd   <= 1'b0;
      end else if (ce_i) begin
         if (st_rd) begin
            rcf_arm <= rcf;
            hi_rd   <= 1'b0;
         end
         if (dh_rd) begin
            hi_rd <= 1'b1;
         end
         // RULE_16 new transfer drops held word
         if (xfer_start) begin
            held_v <= 1'b0;
         end
         if (done_e) begin
            // RULE_02 RULE_13 copy and flag
            if (!rcf) begin
               data_rx <= rx_word;
               rcf     <= 1'b1;
            end else if (rcf_clr && held_v) begin
               data_rx <= held;
               held    <= rx_word;
            end else if (rcf_clr) begin
               data_rx <= rx_word;
            // RULE_14 keep second word
            end else begin
               held   <= rx_word;
               held_v <= 1'b1;
            end
            if (rcf_clr) begin
               rcf_arm <= 1'b0;
            end
         end else if (rcf_clr) begin
            rcf_arm <= 1'b0;
            // RULE_15 move held, flag stays
            if (held_v && !xfer_start) begin
               data_rx <= held;
               held_v  <= 1'b0;
            end else begin
               rcf <= 1'b0;
               // RULE_07 unread high byte lost
               if (transfer_width_select && !hi_rd) begin
                  data_rx[15:8] <= `SSDB_BYTE_RST;
               end
            end
         end
      end
   end

   // transmit side
   logic tef_load;
   assign tef_load = m_start | (s_start & ~tef);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tef     <= 1'b1;
         tef_arm <= 1'b0;
         tx_hi   <= `SSDB_BYTE_RST;
         tx_lo   <= `SSDB_BYTE_RST;
      end else if (ce_i) begin
         if (st_rd) begin
            tef_arm <= tef;
         end
         // RULE_09 writes only while empty
         if (dh_wr && tef) begin
            tx_hi <= dat_i[7:0];
         end
         if (dl_wr && tef) begin
            // RULE_10 high byte left as is
            tx_lo <= dat_i[7:0];
            // RULE_08 armed low write queues
            if (tef_arm) begin
               tef     <= 1'b0;
               tef_arm <= 1'b0;
            end
         end
         // RULE_03 empty again once loaded
         if (tef_load) begin
            tef <= 1'b1;
         end
      end
   end

   // interrupt status, write one to clear, set wins
   logic [2:0] irq_set;
   assign irq_set = {mf_evt, tef_load, done_e & (~rcf | rcf_clr)};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= `SSDB_IRQ_RST;
         irq_mask <= `SSDB_IRQ_RST;
         irq_o    <= 1'b0;
      end else if (ce_i) begin
         irq_stat <= (irq_stat & ~(is_wr ? dat_i[2:0] : `SSDB_IRQ_RST)) | irq_set;
         if (im_wr) begin
            irq_mask <= dat_i[2:0];
         end
         // RULE_17 gated by interrupt enable
         irq_o <= ie & |(irq_stat & irq_mask);
      end
   end

   // bus answer: one wait state, unmapped reads zero
   logic [7:0] rd_val;
   always_comb begin
      rd_val = `SSDB_BYTE_RST;
      case (idx)
         `SSDB_IDX_CTRL1: begin
            rd_val = ctrl1_rest;
            rd_val[`SSDB_C1_MSTR] = mst;
         end
         `SSDB_IDX_CTRL2: rd_val = ctrl2_rest;
         // RULE_01 RULE_18 flags only, rest zero
         `SSDB_IDX_STATUS: begin
            rd_val[`SSDB_ST_RCF] = rcf;
            rd_val[`SSDB_ST_TEF] = tef;
            rd_val[`SSDB_ST_MFF] = mff;
         end
         // RULE_11 data readable anytime
         `SSDB_IDX_DATAH: rd_val = data_rx[15:8];
         `SSDB_IDX_DATAL: rd_val = data_rx[7:0];
         `SSDB_IDX_IRQ_STAT: rd_val = {5'h00, irq_stat};
         `SSDB_IDX_IRQ_MASK: rd_val = {5'h00, irq_mask};
         default: rd_val = `SSDB_BYTE_RST;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce_i) begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         dat_o <= {24'h000000, rd_val};
      end
   end

   // pin drivers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_oe_o  <= 1'b0;
         mosi_o    <= 1'b0;
         mosi_oe_o <= 1'b0;
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
      end else if (ce_i) begin
         sck_oe_o  <= mst;
         mosi_oe_o <= mst;
         miso_oe_o <= ~mst & ~ss_n_s;
         mosi_o    <= top_bit(sh, transfer_width_select);
         miso_o    <= top_bit(sh, transfer_width_select);
      end
   end

   // checks
   sequence queued_done_s;
      done_e && mst && !tef;
   endsequence

   sequence restart_s;
      ##1 (m_start || mf_evt || !ce_i);
   endsequence

   status_ro_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
      st_wr && !done_e && !xfer_start && !mf_evt |=> $stable({rcf, tef, mff}))
      else $error("status write changed a flag");
   rx_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
      done_e && !rcf |=> rcf && data_rx == $past(rx_word))
      else $error("received word not copied");
   tef_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
      tef_load |=> tef)
      else $error("transmit empty not set after load");
   mf_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
      mf_evt |=> mff && !mst)
      else $error("mode fault not flagged");
   mf_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      $fell(mff) |-> $past(c1_wr && mff_arm))
      else $error("mode fault cleared without sequence");
   rcf_hi_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      dh_rd && !done_e |=> rcf == $past(rcf))
      else $error("high byte read touched flag");
   tef_clr_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      $fell(tef) |-> $past(dl_wr && tef_arm))
      else $error("transmit empty cleared without sequence");
   wr_ign_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
      dl_wr && !tef |=> tx_lo == $past(tx_lo))
      else $error("data write taken while full");
   restart_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
      queued_done_s |-> restart_s)
      else $error("queued word not started");
   held_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
      done_e && rcf && !rcf_clr |=> held_v && $stable(data_rx))
      else $error("second word not held");
   held_move_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
      rcf_clr && held_v && !xfer_start && !done_e |=> rcf && data_rx == $past(held))
      else $error("held word not moved");
   held_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
      xfer_start |=> !held_v)
      else $error("held word survived new transfer");
   mf_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
      mf_evt && ie && irq_mask[`SSDB_IRQ_MF] && !c1_wr ##1 ce_i |-> ##1 irq_o)
      else $error("mode fault interrupt missing");

endmodule

// File: pkg/ssdb_consts.svh
// register indices, field positions, reset values and timing of the serial status/data block
// assumes a 32-bit classic Wishbone slave: byte address = 4 * index
`ifndef SSDB_CONSTS_SVH
`define SSDB_CONSTS_SVH

`define SSDB_IDX_CTRL1     4'h0
`define SSDB_IDX_CTRL2     4'h1
`define SSDB_IDX_STATUS    4'h3
`define SSDB_IDX_DATAH     4'h4
`define SSDB_IDX_DATAL     4'h5
`define SSDB_IDX_IRQ_STAT  4'h6
`define SSDB_IDX_IRQ_MASK  4'h7

`define SSDB_ST_RCF        7
`define SSDB_ST_TEF        5
`define SSDB_ST_MFF        4
`define SSDB_C1_IE         7
`define SSDB_C1_MSTR       4
`define SSDB_C2_TRANSFER_WIDTH_SELECT       6
`define SSDB_C2_MFDE       4
`define SSDB_IRQ_RX        0
`define SSDB_IRQ_TX        1
`define SSDB_IRQ_MF        2

`define SSDB_BYTE_RST      8'h00
`define SSDB_IRQ_RST       3'h0
`define SSDB_BITS_NARROW   5'h08
`define SSDB_BITS_WIDE     5'h10

`define SSDB_CLK_NS        50
`define SSDB_SCK_HALF_NS   500

`endif

// File: pkg/ssdb_pkg.sv
// types shared by the serial status/data block
// assumes nothing beyond a SystemVerilog compiler
package ssdb_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } ssdb_state_e;
endpackage

// File: dv/ssdb_link_slave.sv
// far-side serial peripheral: a mode-0 slave that answers the block in master mode
// assumes sck idles low between frames and is only toggled by the block
`timescale 1ns/1ps
module ssdb_link_slave #(
   parameter logic [15:0] TX_WORD = 16'h3C5A
) (
   // link pins
   input  wire logic        sck_i,
   input  wire logic        mosi_i,
   output logic             miso_o,
   // bench view
   output logic      [15:0] rx_word_o,
   output int               bit_count_o
);
   logic [15:0] tx = TX_WORD;
   // the settling of sck at power-up must not count as a falling edge
   logic        seen_rise = 1'b0;

   initial begin
      rx_word_o = 16'h0000;
      bit_count_o = 0;
   end

   // rotating reply: an 8-bit frame takes the top byte, the next frame the other one
   assign miso_o = tx[15];

   // mode 0: sample on the rising edge, next bit after the falling edge
   always @(posedge sck_i) begin
      seen_rise <= 1'b1;
      rx_word_o <= {rx_word_o[14:0], mosi_i};
      bit_count_o <= bit_count_o + 1;
   end

   always @(negedge sck_i) begin
      if (seen_rise)
         tx <= {tx[14:0], tx[15]};
   end
endmodule

// File: dv/spi_status_and_data_buffer_bench.sv
// self-checking bench for the serial status/data block over classic Wishbone
// assumes the far side is the mode-0 slave model; ce_i is held high throughout
`timescale 1ns/1ps
`include "ssdb_consts.svh"
module spi_status_and_data_buffer_bench;
   typedef struct {
      logic       w;
      logic [3:0] idx;
      logic [7:0] d;
      logic [7:0] exp;
   } ssdb_row_s;

   logic        clk_i  = 1'b0;
   logic        rst_i  = 1'b1;
   logic        cyc_i  = 1'b0;
   logic        stb_i  = 1'b0;
   logic        we_i   = 1'b0;
   logic        ss_n_i = 1'b1;
   logic [5:0]  adr_i  = 6'h00;
   logic [3:0]  sel_i  = 4'h0;
   logic [31:0] dat_i  = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o, irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
   logic        far_miso;
   logic [15:0] rx_word;
   logic [7:0]  q;
   int          bit_count;
   int          base;
   int          num_errors = 0;
   int          cmp_count  = 0;
   // wire levels: sck pulled low when nobody drives it
   wire logic   sck  = sck_oe_o ? sck_o : 1'b0;
   wire logic   mosi = mosi_oe_o ? mosi_o : 1'b0;
   wire logic   miso = miso_oe_o ? miso_o : far_miso;

   ssdb_row_s rows [8] = '{
      '{1'b0, 4'h3, 8'h00, 8'h20}, '{1'b1, 4'h3, 8'hFF, 8'h00}, '{1'b0, 4'h3, 8'h00, 8'h20},
      '{1'b0, 4'h4, 8'h00, 8'h00}, '{1'b0, 4'h5, 8'h00, 8'h00}, '{1'b1, 4'h2, 8'hFF, 8'h00},
      '{1'b0, 4'h2, 8'h00, 8'h00}, '{1'b0, 4'h7, 8'h00, 8'h00}};

   always #25 clk_i = ~clk_i;

   // half period 4 clocks gives the 400 ns link clock
   ssdb_core #(.HALF_CYC(4)) u_ssdb_core (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
      .sck_i(sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi), .mosi_o(mosi_o),
      .mosi_oe_o(mosi_oe_o), .miso_i(miso), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i));

   ssdb_link_slave u_ssdb_link_slave (
      .sck_i(sck), .mosi_i(mosi), .miso_o(far_miso), .rx_word_o(rx_word), .bit_count_o(bit_count));

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one classic cycle; read data lands in q at the ack edge
   task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'hF;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      if (n >= 50)
         chk("ack wait", 16'h0, 16'h1);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask

   task automatic rdc(input string what, input logic [3:0] idx, input logic [7:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(what, {8'h00, q}, {8'h00, exp});
   endtask

   // polls status until the given bit shows the given level
   task automatic wait_st(input int b, input logic v);
      int n;
      n = 0;
      do begin
         wb(1'b0, `SSDB_IDX_STATUS, 8'h00);
         n++;
      end while (q[b] !== v && n < 200);
      chk("status poll", {15'h0, q[b]}, {15'h0, v});
   endtask

   task automatic irq_is(input logic v);
      @(posedge clk_i);
      chk("irq level", {15'h0, irq_o}, {15'h0, v});
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wb(rows[i].w, rows[i].idx, rows[i].d);
         if (!rows[i].w)
            chk("table row", {8'h00, q}, {8'h00, rows[i].exp});
      end
      // plain 8-bit master frame
      wb(1'b1, `SSDB_IDX_CTRL1, 8'h10);
      wb(1'b1, `SSDB_IDX_DATAH, 8'h55);
      rdc("high write only", `SSDB_IDX_STATUS, 8'h20);
      wb(1'b1, `SSDB_IDX_DATAL, 8'hA5);
      wait_st(`SSDB_ST_RCF, 1'b1);
      chk("sent byte", {8'h00, rx_word[7:0]}, 16'h00A5);
      rdc("status full", `SSDB_IDX_STATUS, 8'hA0);
      rdc("high read", `SSDB_IDX_DATAH, 8'h00);
      wb(1'b0, `SSDB_IDX_DATAH, 8'h00);
      rdc("high reads keep", `SSDB_IDX_STATUS, 8'hA0);
      rdc("received byte", `SSDB_IDX_DATAL, 8'h3C);
      rdc("flag cleared", `SSDB_IDX_STATUS, 8'h20);
      // back to back frames, a write while full, and an overrun
      base = bit_count;
      wb(1'b1, `SSDB_IDX_DATAL, 8'h12);
      wait_st(`SSDB_ST_TEF, 1'b1);
      wb(1'b1, `SSDB_IDX_DATAL, 8'h34);
      wb(1'b1, `SSDB_IDX_DATAL, 8'hFF);
      for (int n = 0; n < 400 && bit_count < base + 16; n++)
         @(posedge clk_i);
      rdc("first of two", `SSDB_IDX_STATUS, 8'hA0);
      chk("two frames sent", rx_word, 16'h1234);
      rdc("held word waits", `SSDB_IDX_DATAL, 8'h5A);
      rdc("flag stays set", `SSDB_IDX_STATUS, 8'hA0);
      rdc("held word moved", `SSDB_IDX_DATAL, 8'h3C);
      rdc("both serviced", `SSDB_IDX_STATUS, 8'h20);
      chk("no extra frame", bit_count - base, 16);
      // 16-bit frame read back through the low byte only
      wb(1'b1, `SSDB_IDX_CTRL2, 8'h40);
      wb(1'b0, `SSDB_IDX_STATUS, 8'h00);
      wb(1'b1, `SSDB_IDX_DATAH, 8'hC3);
      wb(1'b1, `SSDB_IDX_DATAL, 8'h96);
      wait_st(`SSDB_ST_RCF, 1'b1);
      chk("wide word sent", rx_word, 16'hC396);
      rdc("wide low byte", `SSDB_IDX_DATAL, 8'h3C);
      rdc("high discarded", `SSDB_IDX_DATAH, 8'h00);
      rdc("wide cleared", `SSDB_IDX_STATUS, 8'h20);
      // mode fault, its clearing order and the interrupt line
      rdc("event bits", `SSDB_IDX_IRQ_STAT, 8'h03);
      wb(1'b1, `SSDB_IDX_IRQ_STAT, 8'h07);
      rdc("events cleared", `SSDB_IDX_IRQ_STAT, 8'h00);
      wb(1'b1, `SSDB_IDX_IRQ_MASK, 8'h04);
      wb(1'b1, `SSDB_IDX_CTRL2, 8'h10);
      wb(1'b1, `SSDB_IDX_CTRL1, 8'h90);
      irq_is(1'b0);
      ss_n_i <= 1'b0;
      for (int n = 0; n < 100 && irq_o !== 1'b1; n++)
         @(posedge clk_i);
      ss_n_i <= 1'b1;
      irq_is(1'b1);
      wb(1'b1, `SSDB_IDX_CTRL1, 8'h80);
      rdc("fault kept", `SSDB_IDX_STATUS, 8'h30);
      wb(1'b1, `SSDB_IDX_CTRL1, 8'h80);
      rdc("fault cleared", `SSDB_IDX_STATUS, 8'h20);
      wb(1'b1, `SSDB_IDX_IRQ_MASK, 8'h00);
      irq_is(1'b0);
      wb(1'b1, `SSDB_IDX_IRQ_MASK, 8'h04);
      irq_is(1'b1);
      wb(1'b1, `SSDB_IDX_IRQ_STAT, 8'h04);
      irq_is(1'b0);
      // reset in mid-frame returns flags and pins to idle
      wb(1'b1, `SSDB_IDX_CTRL1, 8'h10);
      wb(1'b0, `SSDB_IDX_STATUS, 8'h00);
      wb(1'b1, `SSDB_IDX_DATAL, 8'h0F);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("sck oe after reset", {15'h0, sck_oe_o}, 16'h0000);
      rdc("status after reset", `SSDB_IDX_STATUS, 8'h20);
      rdc("events after reset", `SSDB_IDX_IRQ_STAT, 8'h00);
      irq_is(1'b0);
      end_of_test();
   end
endmodule
